// ---- design/dmau_address_unit.sv ----
// Data memory address unit: forms the 12-bit operand address for each access.
// Assumes the instruction decoder presents one operand per op_valid cycle and
// the data RAM and flag logic sit outside, driven from the registered outputs.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Window is high bank top plus bank zero bottom
// - Access bit picks window or selected bank
// - Window runs on from low part into high
// - Sixteen banks of at most 256 bytes
// - Bank nibble forms upper address; upper bits zero
// - Missing bank reads zero, drops writes, flags normal
// - File-to-file move uses its full 12-bit address
// - Three 12-bit pointers held as two bytes
// - Port access goes to the pointed location
// - Pointer at a port: read zero, write nothing
// - Five ports per pointer select the mode
// - Offset mode adds signed working register, unchanged
// - Pointer stepping never changes status flags
// - Stepping carries across all twelve bits
// - Written pointer byte beats the step
module dmau_address_unit
  import dmau_pkg::*;
#(
  // One bit per bank; a zero bit marks a bank with no RAM behind it
  parameter logic [BANKS-1:0] IMPLEMENTED_BANKS = 16'hffff
)(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Operand request from the decoder
  input wire logic op_valid,
  input wire logic op_write,
  input wire logic op_move,
  input wire logic access_sel,
  input wire logic [7:0] file_field,
  input wire logic [11:0] move_address,
  input wire logic [7:0] working_register,
  input wire logic [7:0] write_data,
  // Bank literal load
  input wire logic bank_literal_load,
  input wire logic [7:0] bank_literal,
  // Memory request, one cycle after the operand
  output logic mem_valid,
  output logic [11:0] mem_address,
  output logic mem_read_en,
  output logic mem_write_en,
  // Read and flag handling
  output logic read_force_zero,
  output logic zero_flag_force,
  output logic status_hold,
  // Local register read-back
  output logic reg_read_hit,
  output logic [7:0] reg_read_data,
  // Visible state
  output logic [7:0] data_bank_select,
  output logic [11:0] indirect_pointer_0,
  output logic [11:0] indirect_pointer_1,
  output logic [11:0] indirect_pointer_2
);

  // ----------------------------------------------------------------
  // Direct operand address
  // ----------------------------------------------------------------
  logic [3:0] bank;
  wire [3:0] window_bank = (file_field < WINDOW_LOW_LIMIT) ? WINDOW_LOW_BANK : WINDOW_HIGH_BANK;
  wire [3:0] direct_bank = access_sel ? bank : window_bank;
  wire [11:0] direct_address = {direct_bank, file_field};
  wire [11:0] operand_address = op_move ? move_address : direct_address;

  // ----------------------------------------------------------------
  // Indirect decode
  // ----------------------------------------------------------------
  logic [11:0] pointers [POINTERS];
  wire [7:0] op_offset = region_offset(operand_address);
  wire op_port = port_hit(operand_address);
  wire [1:0] port_index = op_offset[4:3];
  wire [2:0] port_mode = op_offset[2:0];
  wire [11:0] selected_pointer = pointers[port_index];
  wire [11:0] signed_index = {{4{working_register[7]}}, working_register};

  logic [11:0] target;
  always_comb begin
    case (port_mode)
      DMAU_PRE_INC: target = selected_pointer + 12'h001;
      DMAU_OFFSET: target = selected_pointer + signed_index;
      default: target = selected_pointer;
    endcase
  end

  wire [11:0] final_address = op_port ? target : operand_address;
  wire self_port = op_port && port_hit(target);
  wire bank_present = IMPLEMENTED_BANKS[final_address[11:8]];

  // Local registers live in the high bank
  wire [7:0] final_offset = region_offset(final_address);
  wire hit_bank_select = (final_address == {WINDOW_HIGH_BANK, BANK_SELECT_OFFSET});
  wire hit_ptr_low = in_region(final_address) && (final_offset[2:0] == PTR_LOW_SLOT);
  wire hit_ptr_high = in_region(final_address) && (final_offset[2:0] == PTR_HIGH_SLOT);
  wire [1:0] hit_index = final_offset[4:3];

  // Writes through a pointer at a port do nothing; missing banks drop writes
  wire do_write = op_valid && op_write && !self_port && bank_present;
  wire do_read = op_valid && !op_write;

  // ----------------------------------------------------------------
  // Bank select register
  // ----------------------------------------------------------------
  logic [3:0] next_bank;
  assign next_bank = (do_write && hit_bank_select) ? write_data[3:0] :
    (bank_literal_load ? bank_literal[3:0] : bank);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bank <= BANK_SELECT_RESET;
    end else begin
      bank <= next_bank;
    end
  end

  // Upper nibble is not stored and always reads zero
  assign data_bank_select = {4'h0, bank};

  // ----------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------
  // Stepping only touches the pointer; no status output depends on it
  genvar gi;
  generate
    for (gi = 0; gi < POINTERS; gi++) begin : g_ptr
      wire mine = op_valid && op_port && (port_index == 2'(gi));
      dmau_pointer u_pointer (
        .clk(clk),
        .reset(reset),
        .step_inc(mine && (port_mode == DMAU_POST_INC || port_mode == DMAU_PRE_INC)),
        .step_dec(mine && (port_mode == DMAU_POST_DEC)),
        .write_low(do_write && hit_ptr_low && (hit_index == 2'(gi))),
        .write_high(do_write && hit_ptr_high && (hit_index == 2'(gi))),
        .write_data(write_data),
        .pointer(pointers[gi])
      );
    end
  endgenerate

  assign indirect_pointer_0 = pointers[0];
  assign indirect_pointer_1 = pointers[1];
  assign indirect_pointer_2 = pointers[2];

  // ----------------------------------------------------------------
  // Read-back of local registers
  // ----------------------------------------------------------------
  wire [11:0] hit_pointer = pointers[hit_index];
  wire local_hit = hit_bank_select || hit_ptr_low || hit_ptr_high;
  wire [7:0] local_data = hit_bank_select ? data_bank_select :
    (hit_ptr_low ? hit_pointer[7:0] : (hit_ptr_high ? {4'h0, hit_pointer[11:8]} : 8'h00));

  // ----------------------------------------------------------------
  // Registered memory request
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_valid <= 1'b0;
      mem_address <= 12'h000;
      mem_read_en <= 1'b0;
      mem_write_en <= 1'b0;
      read_force_zero <= 1'b0;
      zero_flag_force <= 1'b0;
      status_hold <= 1'b0;
      reg_read_hit <= 1'b0;
      reg_read_data <= 8'h00;
    end else begin
      mem_valid <= op_valid;
      mem_address <= final_address;
      mem_read_en <= do_read && !self_port && bank_present;
      mem_write_en <= do_write && !local_hit;
      read_force_zero <= do_read && (self_port || !bank_present);
      zero_flag_force <= do_read && self_port;
      status_hold <= op_valid && op_write && self_port;
      reg_read_hit <= do_read && !self_port && local_hit;
      reg_read_data <= (do_read && !self_port && local_hit) ? local_data : 8'h00;
    end
  end

endmodule : dmau_address_unit

`default_nettype wire

// ---- design/dmau_pkg.sv ----
// Package for the data memory address unit: address map, window limits and modes.
// Assumes a 12-bit data address space split into sixteen 256-byte banks.
package dmau_pkg;

  // ----------------------------------------------------------------
  // Address space
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  localparam int BANKS = 16;
  localparam int POINTERS = 3;

  // ----------------------------------------------------------------
  // Fast access window
  // ----------------------------------------------------------------
  localparam logic [7:0] WINDOW_LOW_LIMIT = 8'h60;
  localparam logic [3:0] WINDOW_LOW_BANK = 4'h0;
  localparam logic [3:0] WINDOW_HIGH_BANK = 4'hf;

  // ----------------------------------------------------------------
  // Special register offsets inside the high bank
  // ----------------------------------------------------------------
  // Each pointer owns an eight-address block: five ports, low byte, high byte
  localparam logic [7:0] PORT_REGION_BASE = 8'hd8;
  localparam logic [7:0] PORT_REGION_SIZE = 8'h18;
  localparam logic [2:0] PTR_LOW_SLOT = 3'h5;
  localparam logic [2:0] PTR_HIGH_SLOT = 3'h6;
  localparam logic [7:0] BANK_SELECT_OFFSET = 8'hf0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] BANK_SELECT_RESET = 4'h0;
  localparam logic [11:0] POINTER_RESET = 12'h000;

  // ----------------------------------------------------------------
  // Indirect access modes, equal to the slot inside a block
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DMAU_PLAIN = 3'h0,
    DMAU_POST_DEC = 3'h1,
    DMAU_POST_INC = 3'h2,
    DMAU_PRE_INC = 3'h3,
    DMAU_OFFSET = 3'h4
  } dmau_mode_e;

  // Offset of an address inside the port region
  function automatic logic [7:0] region_offset(input logic [11:0] addr);
    region_offset = addr[7:0] - PORT_REGION_BASE;
  endfunction : region_offset

  function automatic logic in_region(input logic [11:0] addr);
    in_region = (addr[11:8] == WINDOW_HIGH_BANK) && (addr[7:0] >= PORT_REGION_BASE)
      && (region_offset(addr) < PORT_REGION_SIZE);
  endfunction : in_region

  // True for any of the five indirect ports of any pointer
  function automatic logic port_hit(input logic [11:0] addr);
    port_hit = in_region(addr) && (region_offset(addr) <= {5'h0, 3'(DMAU_OFFSET)} + {region_offset(addr)
      & 8'hf8});
  endfunction : port_hit

endpackage : dmau_pkg

// ---- design/dmau_pointer.sv ----
// One 12-bit indirect pointer with byte writes and automatic stepping.
// Assumes the address unit decides when to step and when a byte is written.
`timescale 1ns/1ps
`default_nettype none

module dmau_pointer
  import dmau_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic step_inc,
  input wire logic step_dec,
  input wire logic write_low,
  input wire logic write_high,
  input wire logic [7:0] write_data,
  // State
  output logic [11:0] pointer
);

  logic [11:0] next_pointer;
  logic [11:0] stepped;
  wire any_write = write_low | write_high;

  // Full 12-bit arithmetic, so the low byte carries into the high byte
  assign stepped = step_inc ? pointer + 12'h001 : (step_dec ? pointer - 12'h001 : pointer);

  // A byte write wins over the step; the untouched byte keeps its old value
  assign next_pointer = any_write ?
    {(write_high ? write_data[3:0] : pointer[11:8]), (write_low ? write_data : pointer[7:0])} :
    stepped;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pointer <= POINTER_RESET;
    end else begin
      pointer <= next_pointer;
    end
  end

endmodule : dmau_pointer

`default_nettype wire

// ---- dv/dmau_core_model.sv ----
// Core-side model: issues one operand at a time to the address unit.
// Assumes inputs change on the falling edge and the unit samples on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module dmau_core_model (
  // Clock
  input wire logic clk,
  // Operand request
  output logic op_valid,
  output logic op_write,
  output logic op_move,
  output logic access_sel,
  output logic [7:0] file_field,
  output logic [11:0] move_address,
  output logic [7:0] working_register,
  output logic [7:0] write_data
);
  initial begin
    {op_valid, op_write, op_move, access_sel} = 4'h0;
    {file_field, move_address, working_register, write_data} = 36'h0;
  end
  // Qualifiers stay put until the next request, only the strobe drops
  task automatic issue(input logic [38:0] op);
    @(negedge clk);
    {op_write, access_sel, op_move, file_field, move_address, working_register, write_data} = op;
    op_valid = 1'b1;
    @(negedge clk);
    op_valid = 1'b0;
  endtask : issue
endmodule : dmau_core_model
`default_nettype wire

// ---- dv/dmau_assertions.sv ----
// Port checker for the data memory address unit.
// Assumes one clock domain and the registered one-cycle answer.
`timescale 1ns/1ps
`default_nettype none
module dmau_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched ports
  input wire logic op_valid,
  input wire logic op_write,
  input wire logic op_move,
  input wire logic access_sel,
  input wire logic [7:0] file_field,
  input wire logic [11:0] move_address,
  input wire logic bank_literal_load,
  input wire logic [7:0] bank_literal,
  input wire logic mem_valid,
  input wire logic [11:0] mem_address,
  input wire logic mem_write_en,
  input wire logic read_force_zero,
  input wire logic zero_flag_force,
  input wire logic status_hold,
  input wire logic [7:0] data_bank_select,
  input wire logic [11:0] indirect_pointer_0
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic win = op_valid && !op_move && !access_sel && !op_write;
  answer_pulse_a: assert property (mem_valid == $past(op_valid)) else $error("answer pulse off");
  bank_upper_a: assert property (data_bank_select[7:4] == 4'h0) else $error("bank upper bits set");
  bank_load_a: assert property (bank_literal_load && !op_valid |=>
    data_bank_select == {4'h0, $past(bank_literal[3:0])}) else $error("bank load wrong");
  window_low_a: assert property (win && file_field < 8'h60 |=>
    mem_address == {4'h0, $past(file_field)}) else $error("low window address");
  window_high_a: assert property (win && file_field >= 8'h60 && file_field < 8'hd8 |=>
    mem_address == {4'hf, $past(file_field)}) else $error("high window address");
  bank_direct_a: assert property (op_valid && access_sel && !op_move && data_bank_select[3:0] != 4'hf |=>
    mem_address == {$past(data_bank_select[3:0]), $past(file_field)}) else $error("banked address");
  move_addr_a: assert property (op_valid && op_move && move_address[11:8] != 4'hf |=>
    mem_address == $past(move_address)) else $error("move address");
  post_inc_a: assert property (win && file_field == 8'hda |=>
    indirect_pointer_0 == $past(indirect_pointer_0) + 12'h1) else $error("pointer step");
  plain_hold_a: assert property (win && file_field == 8'hd8 |=> $stable(indirect_pointer_0))
    else $error("plain port moved pointer");
  port_read_a: assert property (zero_flag_force |-> read_force_zero && !$past(op_write))
    else $error("zero flag without zero read");
  port_write_a: assert property (status_hold |-> !mem_write_en && !zero_flag_force)
    else $error("nop write reached memory");
endmodule : dmau_checker
bind dmau_address_unit dmau_checker i_chk (.clk, .reset, .op_valid, .op_write, .op_move, .access_sel,
  .file_field, .move_address, .bank_literal_load, .bank_literal, .mem_valid, .mem_address, .mem_write_en,
  .read_force_zero, .zero_flag_force, .status_hold, .data_bank_select, .indirect_pointer_0);
`default_nettype wire

// ---- dv/tb.sv ----
// Testbench for the data memory address unit with bank e left out.
// Assumes the core model issues operands; checks land a cycle after each.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic bank_literal_load = 1'b0;
  logic [7:0] bank_literal = 8'h00;
  wire logic op_valid, op_write, op_move, access_sel;
  wire logic [7:0] file_field, working_register, write_data;
  wire logic [11:0] move_address;
  wire logic mem_valid, mem_read_en, mem_write_en, read_force_zero, zero_flag_force, status_hold, reg_read_hit;
  wire logic [7:0] reg_read_data, data_bank_select;
  wire logic [11:0] mem_address, indirect_pointer_0, indirect_pointer_1, indirect_pointer_2;
  int mismatches = 0;
  int n_tests = 0;
  always #12.5 clk = ~clk;
  dmau_core_model i_dmau_core_model (.clk, .op_valid, .op_write, .op_move, .access_sel, .file_field,
    .move_address, .working_register, .write_data);
  dmau_address_unit #(.IMPLEMENTED_BANKS(16'hbfff)) i_dmau_address_unit (.clk, .reset, .op_valid,
    .op_write, .op_move, .access_sel, .file_field, .move_address, .working_register, .write_data,
    .bank_literal_load, .bank_literal, .mem_valid, .mem_address, .mem_read_en, .mem_write_en,
    .read_force_zero, .zero_flag_force, .status_hold, .reg_read_hit, .reg_read_data, .data_bank_select,
    .indirect_pointer_0, .indirect_pointer_1, .indirect_pointer_2);
  // Wide enough for the packed groups of outputs that the scenarios compare in one call
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic op(input logic w, input logic a, input logic m, input logic [7:0] f,
    input logic [11:0] ma, input logic [7:0] wr, input logic [7:0] wd);
    i_dmau_core_model.issue({w, a, m, f, ma, wr, wd});
  endtask : op
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic test_banks();
    check({data_bank_select, indirect_pointer_0}, 20'h0);
    @(negedge clk) {bank_literal_load, bank_literal} = 9'h1f3;
    @(negedge clk) bank_literal_load = 1'b0;
    check(data_bank_select, 8'h03);
    op(0, 1, 0, 8'h44, 12'h0, 8'h0, 8'h0);
    check({mem_valid, mem_read_en, mem_address}, 14'h3344);
    op(1, 0, 0, 8'hf0, 12'h0, 8'h0, 8'hfe);
    op(0, 0, 0, 8'hf0, 12'h0, 8'h0, 8'h0);
    check({reg_read_hit, reg_read_data}, 9'h10e);
    op(0, 1, 0, 8'h10, 12'h0, 8'h0, 8'h0);
    check({read_force_zero, status_hold, mem_address}, 14'h2e10);
    op(1, 1, 0, 8'h10, 12'h0, 8'h0, 8'h55);
    check(mem_write_en, 1'b0);
    op(0, 1, 1, 8'h10, 12'h3a5, 8'h0, 8'h0);
    check(mem_address, 12'h3a5);
    op(0, 0, 0, 8'h5f, 12'h0, 8'h0, 8'h0);
    check(mem_address, 12'h05f);
    op(0, 0, 0, 8'h60, 12'h0, 8'h0, 8'h0);
    check(mem_address, 12'hf60);
    $display("test banks done");
  endtask : test_banks
  task automatic test_modes();
    logic [7:0] fs[5] = '{8'hda, 8'hd9, 8'hdb, 8'hdc, 8'hd8};
    logic [11:0] ea[5] = '{12'h1ff, 12'h200, 12'h200, 12'h1fe, 12'h200};
    logic [11:0] ep[5] = '{12'h200, 12'h1ff, 12'h200, 12'h200, 12'h200};
    op(1, 0, 0, 8'hdd, 12'h0, 8'h0, 8'hff);
    op(1, 0, 0, 8'hde, 12'h0, 8'h0, 8'hf1);
    check(indirect_pointer_0, 12'h1ff);
    for (int i = 0; i < 5; i++) begin
      op(0, 0, 0, fs[i], 12'h0, 8'hfe, 8'h0);
      check(mem_address, ea[i]);
      check(indirect_pointer_0, ep[i]);
    end
    op(1, 0, 0, 8'he5, 12'h0, 8'h0, 8'hff);
    op(1, 0, 0, 8'he6, 12'h0, 8'h0, 8'h0f);
    op(0, 0, 0, 8'he2, 12'h0, 8'h0, 8'h0);
    check({zero_flag_force, indirect_pointer_1}, 13'h0000);
    op(1, 0, 0, 8'he5, 12'h0, 8'h0, 8'hd8);
    op(1, 0, 0, 8'he6, 12'h0, 8'h0, 8'h0f);
    op(0, 0, 0, 8'he0, 12'h0, 8'h0, 8'h0);
    check({read_force_zero, zero_flag_force}, 2'b11);
    op(1, 0, 0, 8'he0, 12'h0, 8'h0, 8'h12);
    check({status_hold, mem_write_en}, 2'b10);
    op(1, 0, 0, 8'hed, 12'h0, 8'h0, 8'hed);
    op(1, 0, 0, 8'hee, 12'h0, 8'h0, 8'h0f);
    op(1, 0, 0, 8'hea, 12'h0, 8'h0, 8'h40);
    check(indirect_pointer_2, 12'hf40);
    $display("test modes done");
  endtask : test_modes
  initial begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    test_banks();
    test_modes();
    results();
  end
  // Watchdog: the sequence needs well under a hundred cycles
  initial begin
    #50000;
    mismatches++;
    results();
  end
endmodule : tb
`default_nettype wire
